/* File: chg_seq_defines.vh */
`ifndef CHG_SEQ_DEFINES_VH
`define CHG_SEQ_DEFINES_VH

// clock rate and interval figures, in kHz, ms and cycles
`define CLK_KHZ         32'h0003D090
`define T_LDO_MS        32'h000000DC
`define T_QUAL_MS       32'h0000001E
`define T_RETRY_MS      32'h000007D0
`define T_DCD_MS        32'h00000258
`define IRQ_PULSE_CYC   16'h0100

// register byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_ILIM       8'h04
`define ADDR_STATUS     8'h08

// control register fields and reset value
`define CTRL_HOST       0
`define CTRL_FORCE      1
`define CTRL_BOOST      2
`define CTRL_DP_LSB     4
`define CTRL_DM_LSB     6
`define CTRL_RST        8'h00

// status register fields
`define ST_INGOOD       0
`define ST_PG           1
`define ST_TYPE_LSB     2
`define ST_BSOFF        5
`define ST_LDO          6
`define ST_STATE_LSB    8

// input current limit codes, 100 mA per step from 100 mA
`define ILIM_RST        5'h04
`define ILIM_500MA      5'h04
`define ILIM_1000MA     5'h09
`define ILIM_1500MA     5'h0E
`define ILIM_2000MA     5'h13
`define ILIM_2100MA     5'h14
`define ILIM_2400MA     5'h17

// source type codes
`define TYPE_NONE       3'h0
`define TYPE_SDP        3'h1
`define TYPE_CDP        3'h2
`define TYPE_DCP        3'h3
`define TYPE_UNKNOWN    3'h5
`define TYPE_NONSTD     3'h6

// data line drive codes
`define DRV_HIZ         2'h0

`endif

/* File: sync2.v */
`timescale 1ns/1ps
module sync2 #(
    parameter W = 1
) (
    input  wire         clock,   // system clock
    input  wire         sys_rst, // synchronous reset
    input  wire [W-1:0] d_in,    // asynchronous inputs
    output reg  [W-1:0] q_out    // synchronised inputs
);
    reg [W-1:0] meta_reg;

    // two stages; only the second stage is read
    always @(posedge clock) begin
        if (sys_rst) begin
            meta_reg <= {W{1'b0}};
            q_out    <= {W{1'b0}};
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule

/* File: hold_timer.v */
`timescale 1ns/1ps
module hold_timer #(
    parameter W = 32
) (
    input  wire         clock,   // system clock
    input  wire         sys_rst, // synchronous reset
    input  wire         run,     // condition being qualified
    input  wire [W-1:0] limit,   // cycles the condition must hold
    output reg          done     // condition held for limit cycles
);
    reg [W-1:0] cnt_reg;

    // any drop of the condition restarts the count from zero
    always @(posedge clock) begin
        if (sys_rst || !run) begin
            cnt_reg <= {W{1'b0}};
            done    <= 1'b0;
        end else if (cnt_reg == limit) begin
            done    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

/* File: charger_input_powerup_seq.v */
`timescale 1ns/1ps
`include "chg_seq_defines.vh"
module charger_input_powerup_seq #(
    parameter [31:0] LDO_DELAY_CYC = `T_LDO_MS * `CLK_KHZ,
    parameter [31:0] QUAL_CYC      = `T_QUAL_MS * `CLK_KHZ,
    parameter [31:0] RETRY_CYC     = `T_RETRY_MS * `CLK_KHZ,
    parameter [31:0] DCD_CYC       = `T_DCD_MS * `CLK_KHZ
) (
    input  wire        clock,                   // 250 MHz clock
    input  wire        sys_rst,                 // sync reset, high
    input  wire [7:0]  addr,                    // register address
    input  wire [31:0] wdata,                   // write data
    input  wire        wr,                      // write strobe
    input  wire        rd,                      // read strobe
    output reg  [31:0] rdata,                   // read data
    input  wire        input_uvlo_ok,           // input above uvlo
    input  wire        battery_uvlo_ok,         // battery above uvlo
    input  wire        input_supply_present,    // input present
    input  wire        above_sleep_margin,      // in > bat + margin
    input  wire        below_sleep_margin,      // in < bat + margin
    input  wire        input_below_ov,          // below overvoltage
    input  wire        input_above_min,         // above minimum
    input  wire        battery_above_depletion, // battery usable
    input  wire        battery_overcurrent,     // discharge over limit
    input  wire        supplement_mode,         // battery assisting
    input  wire        ship_exit_request,       // switch enable method
    input  wire        dcd_contact,             // data contact seen
    input  wire        bc_primary_hit,          // primary detect
    input  wire        bc_secondary_hit,        // secondary detect
    input  wire [2:0]  dplus_window,            // 2p7, 2p0, 1p2
    input  wire [2:0]  dminus_window,           // 2p7, 2p0, 1p2
    output reg         interface_ready,         // port accepts access
    output reg         battery_switch_on,       // battery switch
    output reg         internal_ldo_en,         // regulator enable
    output reg         input_switch_on,         // input blocking sw
    output reg         qualify_load_on,         // test load on input
    output reg         converter_enable,        // converter allowed
    output reg         converter_switching,     // switching active
    output reg         bc_detect_active,        // BC1.2 running
    output reg  [1:0]  dplus_drive_out,         // D+ drive setting
    output reg  [1:0]  dminus_drive_out,        // D- drive setting
    output reg  [4:0]  input_current_limit_out, // limit in force
    output reg         fast_clock_sel,          // 500 kHz domain sel
    output reg         host_irq_n               // irq, low pulse
);
    localparam S_HIZ   = 3'h0;
    localparam S_QUAL  = 3'h1;
    localparam S_RETRY = 3'h2;
    localparam S_DCD   = 3'h3;
    localparam S_PRI   = 3'h4;
    localparam S_SEC   = 3'h5;
    localparam S_NSTD  = 3'h6;
    localparam S_RUN   = 3'h7;

    localparam NIN = 23;

    wire [NIN-1:0] raw_in;
    wire [NIN-1:0] s_in;
    wire           ldo_cond_met;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [31:0] tmr_reg;
    reg         uvlo_prev_reg;
    reg         por_reg;
    reg  [7:0]  ctrl_reg;
    reg  [4:0]  ilim_reg;
    reg         in_good_reg;
    reg         pg_reg;
    reg  [2:0]  type_reg;
    reg         bs_off_reg;
    reg  [15:0] irq_cnt_reg;
    reg         det_done;
    reg  [4:0]  det_ilim;
    reg  [2:0]  det_type;

    wire rst_all = sys_rst | por_reg;

    assign raw_in = {dminus_window, dplus_window, bc_secondary_hit,
                     bc_primary_hit, dcd_contact, ship_exit_request,
                     supplement_mode, battery_overcurrent,
                     battery_above_depletion, input_above_min,
                     input_below_ov, below_sleep_margin,
                     above_sleep_margin, input_supply_present,
                     battery_uvlo_ok, input_uvlo_ok, 3'h0};

    // comparators arrive from the analog side asynchronously
    sync2 #(.W(NIN)) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .d_in    (raw_in),
        .q_out   (s_in)
    );

    wire uvlo_any  = s_in[3] | s_in[4];
    wire present   = s_in[5];
    wire above_slp = s_in[6];
    wire below_slp = s_in[7];
    wire below_ov  = s_in[8];
    wire above_min = s_in[9];
    wire bat_ok    = s_in[10];
    wire bat_oc    = s_in[11];
    wire supp      = s_in[12];
    wire ship_exit = s_in[13];
    wire dcd       = s_in[14];
    wire pri_hit   = s_in[15];
    wire sec_hit   = s_in[16];
    wire [2:0] dpw = s_in[19:17];
    wire [2:0] dmw = s_in[22:20];

    wire boost_sel = ctrl_reg[`CTRL_BOOST];
    wire host_mode = ctrl_reg[`CTRL_HOST];
    wire force_det = ctrl_reg[`CTRL_FORCE];

    // regulator conditions must hold without a break
    assign ldo_cond_met = present &
                          (boost_sel ? below_slp : above_slp);

    wire ldo_ok;
    hold_timer #(.W(32)) u_ldo_tmr (
        .clock   (clock),
        .sys_rst (rst_all),
        .run     (ldo_cond_met),
        .limit   (LDO_DELAY_CYC),
        .done    (ldo_ok)
    );

    // power-on reset on the rising edge of uvlo_any, when the first supply comes up
    always @(posedge clock) begin
        if (sys_rst) begin
            uvlo_prev_reg <= 1'b0;
            por_reg       <= 1'b0;
        end else begin
            uvlo_prev_reg <= uvlo_any;
            por_reg       <= uvlo_any & ~uvlo_prev_reg;
        end
    end

    wire tmr_qual  = (tmr_reg >= QUAL_CYC - 32'h1);
    wire tmr_retry = (tmr_reg >= RETRY_CYC - 32'h1);
    wire tmr_dcd   = (tmr_reg >= DCD_CYC - 32'h1);
    wire qual_bad  = !below_ov || !above_min;

    // adapter class: standard from the hits, non-standard from the line windows
    always @* begin
        det_ilim = `ILIM_500MA;
        det_type = `TYPE_UNKNOWN;
        if (dpw[2] && dmw[1]) begin
            det_ilim = `ILIM_2100MA;
            det_type = `TYPE_NONSTD;
        end else if (dpw[0] && dmw[0]) begin
            det_ilim = `ILIM_2000MA;
            det_type = `TYPE_NONSTD;
        end else if (dpw[1] && dmw[2]) begin
            det_ilim = `ILIM_1000MA;
            det_type = `TYPE_NONSTD;
        end else if (dpw[2] && dmw[2]) begin
            det_ilim = `ILIM_2400MA;
            det_type = `TYPE_NONSTD;
        end
        if (state_reg == S_PRI && !pri_hit) begin
            det_ilim = `ILIM_500MA;
            det_type = `TYPE_SDP;
        end else if (state_reg == S_SEC) begin
            det_ilim = sec_hit ? `ILIM_2400MA : `ILIM_1500MA;
            det_type = sec_hit ? `TYPE_DCP : `TYPE_CDP;
        end
    end

    // sequencing; loss of the regulator conditions aborts
    always @* begin
        state_next = state_reg;
        det_done   = 1'b0;
        case (state_reg)
            S_HIZ: begin
                if (ldo_ok) begin
                    state_next = S_QUAL;
                end
            end
            S_QUAL: begin
                if (qual_bad) begin
                    state_next = S_RETRY;
                end else if (tmr_qual) begin
                    state_next = S_DCD;
                end
            end
            S_RETRY: begin
                if (tmr_retry) begin
                    state_next = S_QUAL;
                end
            end
            S_DCD: begin
                if (dcd) begin
                    state_next = S_PRI;
                end else if (tmr_dcd) begin
                    state_next = S_NSTD;
                end
            end
            S_PRI: begin
                if (pri_hit) begin
                    state_next = S_SEC;
                end else begin
                    state_next = S_RUN;
                    det_done   = 1'b1;
                end
            end
            S_SEC: begin
                state_next = S_RUN;
                det_done   = 1'b1;
            end
            S_NSTD: begin
                state_next = S_RUN;
                det_done   = 1'b1;
            end
            S_RUN: begin
                if (force_det) begin
                    state_next = S_DCD;
                end
            end
            default: begin
                state_next = S_HIZ;
            end
        endcase
        if (!ldo_ok) begin
            state_next = S_HIZ;
            det_done   = 1'b0;
        end
    end

    // state and interval counter restart on every step
    always @(posedge clock) begin
        if (rst_all) begin
            state_reg <= S_HIZ;
            tmr_reg   <= 32'h0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                tmr_reg <= 32'h0;
            end else begin
                tmr_reg <= tmr_reg + 32'h1;
            end
        end
    end

    wire qual_pass = (state_reg == S_QUAL) && (state_next == S_DCD);
    wire wr_ctrl   = wr && (addr == `ADDR_CTRL);
    wire wr_ilim   = wr && (addr == `ADDR_ILIM);

    // registers and flags; a host write to the limit wins
    always @(posedge clock) begin
        if (rst_all) begin
            ctrl_reg    <= `CTRL_RST;
            ilim_reg    <= `ILIM_RST;
            in_good_reg <= 1'b0;
            pg_reg      <= 1'b0;
            type_reg    <= `TYPE_NONE;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg[7:2] <= wdata[7:2];
                ctrl_reg[0]   <= wdata[0];
            end
            // force bit: a host set beats the device clear
            if (wr_ctrl && wdata[`CTRL_FORCE] && host_mode) begin
                ctrl_reg[`CTRL_FORCE] <= 1'b1;
            end else if (det_done || !host_mode) begin
                ctrl_reg[`CTRL_FORCE] <= 1'b0;
            end
            if (wr_ilim) begin
                ilim_reg <= wdata[4:0];
            end else if (det_done) begin
                ilim_reg <= det_ilim;
            end
            if (state_next == S_HIZ) begin
                in_good_reg <= 1'b0;
                pg_reg      <= 1'b0;
                type_reg    <= `TYPE_NONE;
            end else begin
                if (qual_pass) begin
                    in_good_reg <= 1'b1;
                end
                if (det_done) begin
                    pg_reg   <= 1'b1;
                    type_reg <= det_type;
                end
            end
        end
    end

    // battery switch: overcurrent trip latches open
    always @(posedge clock) begin
        if (rst_all) begin
            bs_off_reg        <= 1'b0;
            battery_switch_on <= 1'b0;
        end else begin
            if (supp && bat_oc) begin
                bs_off_reg <= 1'b1;
            end else if (present || ship_exit) begin
                bs_off_reg <= 1'b0;
            end
            if (supp && bat_oc) begin
                battery_switch_on <= 1'b0;
            end else if (bs_off_reg && !present && !ship_exit) begin
                battery_switch_on <= 1'b0;
            end else begin
                battery_switch_on <= bat_ok | present;
            end
        end
    end

    // power path outputs; all enables off while high-impedance, limit follows ilim_reg
    always @(posedge clock) begin
        if (rst_all) begin
            internal_ldo_en         <= 1'b0;
            input_switch_on         <= 1'b0;
            qualify_load_on         <= 1'b0;
            converter_enable        <= 1'b0;
            converter_switching     <= 1'b0;
            bc_detect_active        <= 1'b0;
            input_current_limit_out <= `ILIM_RST;
            fast_clock_sel          <= 1'b0;
        end else begin
            internal_ldo_en   <= (state_next != S_HIZ);
            input_switch_on   <= (state_next == S_RUN);
            qualify_load_on   <= (state_next == S_QUAL);
            converter_enable  <= (state_next == S_RUN) &&
                                 !force_det;
            converter_switching <= (state_next == S_RUN) &&
                                   !force_det && !below_slp;
            bc_detect_active  <= (state_next == S_DCD) ||
                                 (state_next == S_PRI) ||
                                 (state_next == S_SEC);
            input_current_limit_out <= ilim_reg;
            fast_clock_sel    <= (state_next != S_HIZ);
        end
    end

    // host drive gives way to BC1.2, masked on the edge detection starts
    always @(posedge clock) begin
        if (rst_all) begin
            dplus_drive_out  <= `DRV_HIZ;
            dminus_drive_out <= `DRV_HIZ;
        end else if (state_next == S_DCD || state_next == S_PRI ||
                     state_next == S_SEC) begin
            dplus_drive_out  <= `DRV_HIZ;
            dminus_drive_out <= `DRV_HIZ;
        end else begin
            dplus_drive_out  <= ctrl_reg[`CTRL_DP_LSB +: 2];
            dminus_drive_out <= ctrl_reg[`CTRL_DM_LSB +: 2];
        end
    end

    // long low pulse so a slow host still sees it
    always @(posedge clock) begin
        if (rst_all) begin
            irq_cnt_reg <= 16'h0;
            host_irq_n  <= 1'b1;
        end else begin
            if (qual_pass || det_done) begin
                irq_cnt_reg <= `IRQ_PULSE_CYC;
            end else if (irq_cnt_reg != 16'h0) begin
                irq_cnt_reg <= irq_cnt_reg - 16'h1;
            end
            host_irq_n <= !(qual_pass || det_done ||
                            irq_cnt_reg > 16'h1);
        end
    end

    // register read port; unmapped addresses read zero
    always @(posedge clock) begin
        if (rst_all) begin
            rdata           <= 32'h0;
            interface_ready <= 1'b0;
        end else begin
            interface_ready <= 1'b1;
            rdata           <= 32'h0;
            if (rd && addr == `ADDR_CTRL) begin
                rdata <= {24'h0, ctrl_reg};
            end else if (rd && addr == `ADDR_ILIM) begin
                rdata <= {27'h0, ilim_reg};
            end else if (rd && addr == `ADDR_STATUS) begin
                rdata <= {21'h0, state_reg, 1'b0, internal_ldo_en,
                          bs_off_reg, type_reg, pg_reg, in_good_reg};
            end
        end
    end
endmodule

/* File: seq_monitor.sv */
`timescale 1ns/1ps
module seq_monitor #(
    parameter [31:0] LDO_DELAY_CYC = 32'h00000014
) (
    input wire        clock,                   // clock
    input wire        sys_rst,                 // reset
    input wire [7:0]  addr,                    // address
    input wire [31:0] wdata,                   // write data
    input wire        wr,                      // write strobe
    input wire        input_supply_present,    // supply pin
    input wire        below_sleep_margin,      // sleep pin
    input wire        battery_overcurrent,     // overcurrent pin
    input wire        supplement_mode,         // supplement pin
    input wire        ship_exit_request,       // exit pin
    input wire        internal_ldo_en,         // regulator
    input wire        converter_enable,        // converter
    input wire        converter_switching,     // switching
    input wire        bc_detect_active,        // detecting
    input wire [1:0]  dplus_drive_out,         // D+ drive
    input wire [1:0]  dminus_drive_out,        // D- drive
    input wire [4:0]  input_current_limit_out, // limit
    input wire        host_irq_n,              // irq
    input wire        battery_switch_on        // battery switch
);
    reg [31:0] present_cnt_reg;
    // counts the pin itself, so sync latency only adds slack
    always @(posedge clock) begin
        if (sys_rst || !input_supply_present)
            present_cnt_reg <= 32'h0;
        else if (present_cnt_reg != 32'hFFFFFFFF)
            present_cnt_reg <= present_cnt_reg + 32'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence trip_hold;
        (supplement_mode && battery_overcurrent && !input_supply_present
            && !ship_exit_request)[*4];
    endsequence
    sequence ilim_write;
        (wr && addr == 8'h04) ##1 !(wr && addr == 8'h04);
    endsequence
    irq_width_a: assert property (
        $fell(host_irq_n) |-> (!host_irq_n)[*8]) else $error("irq short");
    battery_trip_a: assert property (
        trip_hold |-> !battery_switch_on) else $error("switch not open");
    limit_write_a: assert property (
        ilim_write |=> input_current_limit_out == $past(wdata[4:0], 2))
        else $error("limit not applied");
    ldo_delay_a: assert property (
        $rose(internal_ldo_en) |-> present_cnt_reg >= LDO_DELAY_CYC)
        else $error("regulator early");
    sleep_stop_a: assert property (
        below_sleep_margin[*4] |-> !converter_switching)
        else $error("switching in sleep");
    drive_mask_a: assert property (
        bc_detect_active |->
        dplus_drive_out == 2'h0 && dminus_drive_out == 2'h0)
        else $error("drive during detection");
    detect_ldo_a: assert property (
        bc_detect_active |-> internal_ldo_en) else $error("detect no ldo");
    conv_order_a: assert property (
        bc_detect_active && $past(bc_detect_active) |-> !converter_enable)
        else $error("converter during detection");
endmodule
bind charger_input_powerup_seq seq_monitor #(
    .LDO_DELAY_CYC(LDO_DELAY_CYC)) seq_monitor_inst (.clock, .sys_rst,
    .addr, .wdata, .wr, .input_supply_present, .below_sleep_margin,
    .battery_overcurrent, .supplement_mode, .ship_exit_request,
    .internal_ldo_en, .converter_enable, .converter_switching,
    .bc_detect_active, .dplus_drive_out, .dminus_drive_out,
    .input_current_limit_out, .host_irq_n, .battery_switch_on);

/* File: usb_adapter_model.sv */
`timescale 1ns/1ps
module usb_adapter_model (
    input  wire       clock,     // clock
    input  wire       detecting, // device detecting
    input  wire [2:0] kind,      // adapter under test
    input  wire [3:0] delay,     // contact delay, cycles
    output reg        contact,   // data contact
    output reg        primary,   // primary hit
    output reg        secondary, // secondary hit
    output reg  [2:0] dp_win,    // D+ windows
    output reg  [2:0] dm_win     // D- windows
);
    reg [3:0] wait_reg;
    // standard ports: contact after a settling delay; hits as levels
    always @(posedge clock) begin
        wait_reg <= !detecting ? 4'h0 : wait_reg + {3'h0, wait_reg != 4'hF};
        contact <= detecting && kind < 3'h3 && wait_reg >= delay;
        primary <= detecting && (kind == 3'h1 || kind == 3'h2);
        secondary <= detecting && kind == 3'h2;
    end
    // divider windows stand while plugged; others never touch them
    always @* begin
        case (kind)
            3'h3: {dp_win, dm_win} = 6'h22;
            3'h4: {dp_win, dm_win} = 6'h09;
            3'h5: {dp_win, dm_win} = 6'h14;
            3'h6: {dp_win, dm_win} = 6'h24;
            default: {dp_win, dm_win} = 6'h00;
        endcase
    end
endmodule

/* File: test_charger_input_powerup_seq.sv */
`timescale 1ns/1ps
`include "chg_seq_defines.vh"
`define CHK(nm, ex, got) begin samples_checked = samples_checked + 1; \
    if ((got) !== (ex)) begin n_errors = n_errors + 1; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
`define WAIT(c) for (k = 0; k < 400 && !(c); k = k + 1) @(posedge clock);
module test_charger_input_powerup_seq;
    reg clock = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg input_uvlo_ok = 1'b0, battery_uvlo_ok = 1'b1, ship_exit_request = 1'b0;
    reg input_supply_present = 1'b0, above_sleep_margin = 1'b0;
    reg below_sleep_margin = 1'b0, input_below_ov = 1'b1, input_above_min = 1'b0;
    reg battery_above_depletion = 1'b1, battery_overcurrent = 1'b0;
    reg supplement_mode = 1'b0;
    reg [2:0] kind = 3'h0;
    reg [3:0] dly = 4'h2;
    reg [15:0] rnd = 16'h2013;
    reg [63:0] exp_q[$];
    reg [63:0] note;
    integer n_errors = 0, samples_checked = 0, cycles = 0, k, t;
    wire dcd_contact, bc_primary_hit, bc_secondary_hit, interface_ready;
    wire battery_switch_on, internal_ldo_en, input_switch_on, qualify_load_on;
    wire converter_enable, converter_switching, bc_detect_active;
    wire fast_clock_sel, host_irq_n;
    wire [2:0] dplus_window, dminus_window;
    wire [31:0] rdata;
    wire [4:0] input_current_limit_out;
    wire [1:0] dplus_drive_out, dminus_drive_out;
    charger_input_powerup_seq #(.LDO_DELAY_CYC(32'h14), .QUAL_CYC(32'hA),
        .RETRY_CYC(32'h1E), .DCD_CYC(32'hF))
        charger_input_powerup_seq_inst (.*);
    usb_adapter_model usb_adapter_model_inst (.clock,
        .detecting(bc_detect_active), .kind, .delay(dly),
        .contact(dcd_contact), .primary(bc_primary_hit),
        .secondary(bc_secondary_hit), .dp_win(dplus_window),
        .dm_win(dminus_window));
    always #2 clock = ~clock;
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected {type, limit} for each adapter kind
    function [7:0] expect_of(input [2:0] a);
        case (a)
            3'h0: expect_of = {`TYPE_SDP, `ILIM_500MA};
            3'h1: expect_of = {`TYPE_CDP, `ILIM_1500MA};
            3'h2: expect_of = {`TYPE_DCP, `ILIM_2400MA};
            3'h3: expect_of = {`TYPE_NONSTD, `ILIM_2100MA};
            3'h4: expect_of = {`TYPE_NONSTD, `ILIM_2000MA};
            3'h5: expect_of = {`TYPE_NONSTD, `ILIM_1000MA};
            3'h6: expect_of = {`TYPE_NONSTD, `ILIM_2400MA};
            default: expect_of = {`TYPE_UNKNOWN, `ILIM_500MA};
        endcase
    endfunction
    task print_verdict;
        begin
            $display("checks %0d errors %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // gap cycle: no strobe assigned twice per step
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clock);
            wr <= 1'b0;
            @(posedge clock);
        end
    endtask
    task rd_reg(input [7:0] a, input [31:0] mask, input [31:0] ex);
        begin
            exp_q.push_back({mask, ex & mask});
            addr <= a;
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            @(posedge clock);
        end
    endtask
    task check_detect(input [2:0] a);
        reg [7:0] e;
        begin
            e = expect_of(a);
            `WAIT(!bc_detect_active)
            repeat (4) @(posedge clock);
            rd_reg(`ADDR_ILIM, 32'h1F, {27'h0, e[4:0]});
            rd_reg(`ADDR_STATUS, 32'h5F, {25'h0, 2'h2, e[7:5], 2'h3});
            `CHK("converter", 1'b1, converter_enable)
        end
    endtask
    // read data stands one cycle after the strobe
    always @(posedge clock) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            `CHK("read", note[31:0], rdata & note[63:32])
        end
        rd_seen <= rd;
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clock);
        `CHK("ready", 1'b1, interface_ready)
        `CHK("bat sw", 1'b1, battery_switch_on)
        `CHK("ldo", 1'b0, internal_ldo_en)
        rd_reg(8'h0C, 32'hFFFFFFFF, 32'h0);
        rnd = lfsr(rnd);
        wr_reg(`ADDR_ILIM, {16'h0, rnd});
        rd_reg(`ADDR_ILIM, 32'h1F, {27'h0, rnd[4:0]});
        `CHK("limit", rnd[4:0], input_current_limit_out)
        battery_uvlo_ok <= 1'b0;
        repeat (4) @(posedge clock);
        battery_uvlo_ok <= 1'b1;
        repeat (8) @(posedge clock);
        rd_reg(`ADDR_ILIM, 32'h1F, 32'h4);
        wr_reg(`ADDR_CTRL, 32'h2);
        rd_reg(`ADDR_CTRL, 32'hFF, 32'h0);
        supplement_mode <= 1'b1;
        battery_overcurrent <= 1'b1;
        repeat (4) @(posedge clock);
        battery_overcurrent <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK("bat open", 1'b0, battery_switch_on)
        rd_reg(`ADDR_STATUS, 32'h20, 32'h20);
        supplement_mode <= 1'b0;
        wr_reg(`ADDR_CTRL, 32'h1);
        input_uvlo_ok <= 1'b1;
        input_supply_present <= 1'b1;
        above_sleep_margin <= 1'b1;
        repeat (16) @(posedge clock);
        `CHK("ldo early", 1'b0, internal_ldo_en)
        `CHK("bat back", 1'b1, battery_switch_on)
        `WAIT(qualify_load_on)
        `CHK("ldo on", 1'b1, internal_ldo_en)
        `CHK("fast clk", 1'b1, fast_clock_sel)
        `WAIT(!qualify_load_on)
        input_above_min <= 1'b1;
        repeat (26) @(posedge clock);
        `CHK("retry wait", 1'b0, qualify_load_on || bc_detect_active)
        `WAIT(bc_detect_active)
        `CHK("retry time", 1'b1, k < 30)
        `WAIT(!host_irq_n)
        `CHK("irq", 1'b0, host_irq_n)
        check_detect(3'h0);
        for (t = 1; t < 8; t = t + 1) begin
            rnd = lfsr(rnd);
            kind <= t[2:0];
            dly <= {1'b0, rnd[2:0]};
            wr_reg(`ADDR_CTRL, 32'h33);
            `WAIT(bc_detect_active)
            `CHK("dp masked", 2'h0, dplus_drive_out)
            check_detect(t[2:0]);
            rd_reg(`ADDR_CTRL, 32'hFF, 32'h31);
            `CHK("dp set", 2'h3, dplus_drive_out)
        end
        below_sleep_margin <= 1'b1;
        repeat (6) @(posedge clock);
        `CHK("sleep", 1'b0, converter_switching)
        input_supply_present <= 1'b0;
        repeat (6) @(posedge clock);
        `CHK("hiz ldo", 1'b0, internal_ldo_en)
        `CHK("hiz sw", 1'b0, input_switch_on)
        print_verdict;
    end
endmodule
